// [common/l1m_pkg.sv]
package l1m_pkg;

    // Cache geometry
    localparam int NUM_SETS = 128;
    localparam int NUM_WAYS = 8;
    localparam int SET_W    = 7;
    localparam int WAY_W    = 3;
    localparam int TAG_W    = 20;
    localparam int PLRU_W   = 7;

    // Tree bits after reset or flash invalidate: all zero walks to way 0
    localparam logic [PLRU_W-1:0] PLRU_RST = 7'h00;

    // Zero-block on a hit takes four core clocks, counted 0..3
    localparam int         ZERO_CLOCKS = 4;
    localparam logic [1:0] ZERO_FIRST  = 2'h0;
    localparam logic [1:0] ZERO_LAST   = 2'(ZERO_CLOCKS - 1);

    // Register byte offsets on the plain register port
    localparam int         REG_AW   = 4;
    localparam logic [3:0] REG_CFG  = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;

    // Configuration register fields
    localparam int CFG_BCAST = 0;
    localparam int CFG_DEN   = 1;
    localparam int CFG_DLOCK = 2;
    localparam int CFG_L2EN  = 3;
    localparam int CFG_DFI   = 4;
    localparam int CFG_IFI   = 5;

    // Status register fields
    localparam int STAT_BUSY  = 0;
    localparam int STAT_CO    = 1;
    localparam int STAT_DSI   = 2;
    localparam int STAT_ALIGN = 3;
    localparam int STAT_PRIV  = 4;

    // Configuration after reset: everything off
    localparam logic CFG_RST = 1'h0;

    // Memory attribute bit positions: write-through, inhibited, coherent, guarded
    localparam int MA_W = 3;
    localparam int MA_I = 2;
    localparam int MA_M = 1;
    localparam int MA_G = 0;

    // Maintenance and access operations from the load/store unit
    typedef enum logic [2:0] {
        OP_LOAD, OP_TOUCH, OP_ZERO, OP_STORE, OP_FLUSH, OP_INVAL, OP_ICBI, OP_IFILL
    } l1m_op_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_BCAST, ST_ACT, ST_WB, ST_ZERO, ST_FILL, ST_CAST
    } l1m_state_t;

endpackage : l1m_pkg

// [hw/l1m_ctrl.sv]
`timescale 1ns/1ps
module l1m_ctrl
    import l1m_pkg::*;
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               srst,
    // Register port
    input  wire logic [REG_AW-1:0]  reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [31:0]        reg_rdata,
    // Operation request from the load/store unit
    input  wire logic               op_valid,
    output logic                    op_ready,
    input  wire l1m_op_t            op_kind,
    input  wire logic [SET_W-1:0]   op_set,
    input  wire logic [TAG_W-1:0]   op_tag,
    // Translation results for the request
    input  wire logic               xlat_hit,
    input  wire logic               prot_load_ok,
    input  wire logic               prot_store_ok,
    input  wire logic               seg_direct_store,
    input  wire logic [3:0]         memory_attribute_bits,
    input  wire logic               problem_state_privilege,
    // Operation outcome
    output logic                    op_done,
    output logic [WAY_W-1:0]        op_way,
    output logic                    exc_dsi,
    output logic                    exc_align,
    output logic                    exc_priv,
    output logic                    ref_bit_set,
    output logic                    tlb_lru_touch,
    // System bus broadcast
    output logic                    bus_req,
    output l1m_op_t                 bus_kind,
    input  wire logic               bus_ack,
    // L2 forwarding
    output logic                    l2_fwd,
    output l1m_op_t                 l2_kind,
    // Write-back, fill and castout
    output logic                    wb_req,
    input  wire logic               wb_ack,
    output logic                    fill_req,
    input  wire logic               fill_done,
    output logic                    co_req,
    output logic                    co_to_l2,
    output logic [SET_W-1:0]        co_set,
    output logic [TAG_W-1:0]        co_tag,
    input  wire logic               co_ack,
    // Data array clear and block coordinates
    output logic                    blk_clear,
    output logic [SET_W-1:0]        blk_set,
    output logic [WAY_W-1:0]        blk_way,
    // Snoop from other masters
    input  wire logic               snp_valid,
    input  wire logic               snp_kill,
    input  wire logic               snp_coherent,
    input  wire logic [SET_W-1:0]   snp_set,
    input  wire logic [TAG_W-1:0]   snp_tag
);

    typedef struct packed {
        l1m_state_t          st;
        l1m_op_t             op;
        logic [SET_W-1:0]    set;
        logic [TAG_W-1:0]    tag;
        logic [WAY_W-1:0]    way;
        logic                hit;
        logic [1:0]          cnt;
        logic                bcast;
        logic                den;
        logic                dlock;
        logic                l2en;
        logic                dfi;
        logic                ifi;
        logic                done;
        logic                dsi;
        logic                align;
        logic                priv;
        logic                refb;
        logic                l2f;
        logic                last_dsi;
        logic                last_align;
        logic                last_priv;
        logic                co_valid;
        logic [SET_W-1:0]    co_set;
        logic [TAG_W-1:0]    co_tag;
        logic [31:0]         rdata;
    } l1m_regs_t;

    l1m_regs_t s;
    l1m_regs_t next_s;

    // Per-set state
    logic [NUM_WAYS-1:0]              dvalid [NUM_SETS];
    logic [NUM_WAYS-1:0]              dmod   [NUM_SETS];
    logic [PLRU_W-1:0]                dplru  [NUM_SETS];
    logic [NUM_WAYS-1:0][TAG_W-1:0]   dtag   [NUM_SETS];
    logic [NUM_WAYS-1:0]              ivalid [NUM_SETS];
    logic [PLRU_W-1:0]                iplru  [NUM_SETS];

    // Array write controls
    logic [SET_W-1:0]  aw_set;
    logic [WAY_W-1:0]  aw_way;
    logic              aw_en;
    logic              aw_valid;
    logic              aw_mod;
    logic              aw_tag_en;
    logic              ap_en;
    logic              i_clr;
    logic              i_fill;
    logic [WAY_W-1:0]  i_way;
    logic              sn_en;
    logic [WAY_W-1:0]  sn_way;

    // Tree update on a hit
    function automatic logic [PLRU_W-1:0] l1m_plru_hit(input logic [PLRU_W-1:0] p,
                                                        input logic [WAY_W-1:0]  w);
        logic [PLRU_W-1:0] r;
        r    = p;
        r[0] = ~w[2];
        if (!w[2]) begin
            r[1] = ~w[1];
            if (!w[1]) r[3] = ~w[0];
            else       r[4] = ~w[0];
        end else begin
            r[2] = ~w[1];
            if (!w[1]) r[5] = ~w[0];
            else       r[6] = ~w[0];
        end
        return r;
    endfunction : l1m_plru_hit

    // Victim: lowest invalid way, else the tree walk
    function automatic logic [WAY_W-1:0] l1m_victim(input logic [NUM_WAYS-1:0] v,
                                                     input logic [PLRU_W-1:0]   p);
        logic [WAY_W-1:0] w;
        if (!p[0]) begin
            w = {1'b0, p[1], (p[1] ? p[4] : p[3])};
        end else begin
            w = {1'b1, p[2], (p[2] ? p[6] : p[5])};
        end
        for (int i = NUM_WAYS - 1; i >= 0; i--) begin
            if (!v[i]) w = WAY_W'(i);
        end
        return w;
    endfunction : l1m_victim

    // Tag compare across all ways of a set: {hit, way}
    function automatic logic [WAY_W:0] l1m_lookup(input logic [NUM_WAYS-1:0]            v,
                                                   input logic [NUM_WAYS-1:0][TAG_W-1:0] t,
                                                   input logic [TAG_W-1:0]               tag);
        logic [WAY_W:0] r;
        r = '0;
        for (int i = 0; i < NUM_WAYS; i++) begin
            if (v[i] && t[i] == tag && !r[WAY_W]) r = {1'b1, WAY_W'(i)};
        end
        return r;
    endfunction : l1m_lookup

    logic [WAY_W:0]    op_lk;
    logic [WAY_W:0]    act_lk;
    logic [WAY_W:0]    snp_lk;
    logic [WAY_W-1:0]  op_vict;
    logic              op_vict_mod;
    logic              ma_w;
    logic              ma_i;
    logic              ma_m;

    assign op_lk       = l1m_lookup(dvalid[op_set], dtag[op_set], op_tag);
    assign act_lk      = l1m_lookup(dvalid[s.set], dtag[s.set], s.tag);
    assign snp_lk      = l1m_lookup(dvalid[snp_set], dtag[snp_set], snp_tag);
    assign op_vict     = l1m_victim(dvalid[op_set], dplru[op_set]);
    assign op_vict_mod = dvalid[op_set][op_vict] & dmod[op_set][op_vict];
    assign ma_w        = memory_attribute_bits[MA_W];
    assign ma_i        = memory_attribute_bits[MA_I];
    assign ma_m        = memory_attribute_bits[MA_M];

    always_comb begin
        next_s    = s;
        next_s.done  = 1'b0;
        next_s.dsi   = 1'b0;
        next_s.align = 1'b0;
        next_s.priv  = 1'b0;
        next_s.refb  = 1'b0;
        next_s.l2f   = 1'b0;
        next_s.dfi   = 1'b0;
        next_s.ifi   = 1'b0;
        next_s.rdata = '0;
        aw_set    = (s.st == ST_IDLE) ? op_set : s.set;
        aw_way    = s.way;
        aw_en     = 1'b0;
        aw_valid  = 1'b0;
        aw_mod    = 1'b0;
        aw_tag_en = 1'b0;
        ap_en     = 1'b0;
        i_clr     = 1'b0;
        i_fill    = 1'b0;
        i_way     = l1m_victim(ivalid[op_set], iplru[op_set]);
        sn_way    = snp_lk[WAY_W-1:0];
        sn_en     = snp_valid && snp_kill && snp_coherent && snp_lk[WAY_W] && s.den;

        // Register port
        if (reg_wr && reg_addr == REG_CFG) begin
            next_s.bcast = reg_wdata[CFG_BCAST];
            next_s.den   = reg_wdata[CFG_DEN];
            next_s.dlock = reg_wdata[CFG_DLOCK];
            next_s.l2en  = reg_wdata[CFG_L2EN];
            next_s.dfi   = reg_wdata[CFG_DFI];
            next_s.ifi   = reg_wdata[CFG_IFI];
        end
        if (reg_rd && reg_addr == REG_CFG) begin
            next_s.rdata[CFG_BCAST] = s.bcast;
            next_s.rdata[CFG_DEN]   = s.den;
            next_s.rdata[CFG_DLOCK] = s.dlock;
            next_s.rdata[CFG_L2EN]  = s.l2en;
        end else if (reg_rd && reg_addr == REG_STAT) begin
            next_s.rdata[STAT_BUSY]  = (s.st != ST_IDLE);
            next_s.rdata[STAT_CO]    = s.co_valid;
            next_s.rdata[STAT_DSI]   = s.last_dsi;
            next_s.rdata[STAT_ALIGN] = s.last_align;
            next_s.rdata[STAT_PRIV]  = s.last_priv;
        end

        case (s.st)
            ST_IDLE: begin
                if (op_valid) begin
                    next_s.op  = op_kind;
                    next_s.set = op_set;
                    next_s.tag = op_tag;
                    next_s.hit = op_lk[WAY_W];
                    next_s.way = op_lk[WAY_W] ? op_lk[WAY_W-1:0] : op_vict;
                    next_s.cnt = ZERO_FIRST;
                    next_s.done = 1'b1;
                    case (op_kind)
                        OP_LOAD, OP_TOUCH: begin
                            if (op_kind == OP_LOAD && !(xlat_hit && prot_load_ok)) begin
                                next_s.dsi = 1'b1;
                            end else if (xlat_hit && prot_load_ok && !seg_direct_store
                                         && !ma_i && s.den) begin
                                next_s.refb = 1'b1;
                                if (op_lk[WAY_W]) begin
                                    aw_way = op_lk[WAY_W-1:0];
                                    ap_en  = 1'b1;
                                end else if (!s.dlock) begin
                                    next_s.done = 1'b0;
                                    next_s.st   = ST_FILL;
                                    if (op_vict_mod) begin
                                        next_s.co_valid = 1'b1;
                                        next_s.co_set   = op_set;
                                        next_s.co_tag   = dtag[op_set][op_vict];
                                    end
                                end
                            end
                        end
                        OP_ZERO: begin
                            if (!(xlat_hit && prot_store_ok)) begin
                                next_s.dsi = 1'b1;
                            end else if (!s.den || ma_i || ma_w) begin
                                next_s.align = 1'b1;
                            end else begin
                                next_s.done = 1'b0;
                                next_s.l2f  = 1'b1;
                                next_s.st   = ma_m ? ST_BCAST : ST_ZERO;
                                if (!op_lk[WAY_W] && op_vict_mod) begin
                                    next_s.co_valid = 1'b1;
                                    next_s.co_set   = op_set;
                                    next_s.co_tag   = dtag[op_set][op_vict];
                                end
                            end
                        end
                        OP_STORE, OP_FLUSH, OP_INVAL: begin
                            if (op_kind == OP_INVAL && problem_state_privilege) begin
                                next_s.priv = 1'b1;
                            end else if (!xlat_hit || (op_kind == OP_INVAL ? !prot_store_ok
                                                        : !prot_load_ok)) begin
                                next_s.dsi = 1'b1;
                            end else begin
                                next_s.done = 1'b0;
                                next_s.l2f  = 1'b1;
                                next_s.st   = s.bcast ? ST_BCAST : ST_ACT;
                            end
                        end
                        OP_ICBI: begin
                            i_clr = 1'b1;
                        end
                        default: begin
                            i_fill     = 1'b1;
                            next_s.way = i_way;
                        end
                    endcase
                end
            end
            ST_BCAST: begin
                if (bus_ack) next_s.st = (s.op == OP_ZERO) ? ST_ZERO : ST_ACT;
            end
            ST_ACT: begin
                next_s.way = act_lk[WAY_W-1:0];
                if (act_lk[WAY_W] && dmod[s.set][act_lk[WAY_W-1:0]] && s.op != OP_INVAL) begin
                    next_s.st = ST_WB;
                end else begin
                    next_s.st   = ST_IDLE;
                    next_s.done = 1'b1;
                    if (act_lk[WAY_W] && s.op != OP_STORE) begin
                        aw_way = act_lk[WAY_W-1:0];
                        aw_en  = 1'b1;
                    end
                end
            end
            ST_WB: begin
                if (wb_ack) begin
                    aw_en       = 1'b1;
                    aw_valid    = (s.op == OP_STORE);
                    next_s.st   = ST_IDLE;
                    next_s.done = 1'b1;
                end
            end
            ST_ZERO: begin
                next_s.cnt = s.cnt + 2'h1;
                if (s.cnt == ZERO_FIRST) begin
                    aw_en     = 1'b1;
                    aw_valid  = 1'b1;
                    aw_tag_en = !s.hit;
                end
                if (s.cnt == ZERO_LAST) begin
                    aw_en     = 1'b1;
                    aw_valid  = 1'b1;
                    aw_mod    = 1'b1;
                    ap_en     = 1'b1;
                    next_s.st   = s.co_valid ? ST_CAST : ST_IDLE;
                    next_s.done = !s.co_valid;
                end
            end
            ST_FILL: begin
                if (fill_done) begin
                    aw_en       = 1'b1;
                    aw_valid    = 1'b1;
                    aw_tag_en   = 1'b1;
                    ap_en       = 1'b1;
                    next_s.st   = s.co_valid ? ST_CAST : ST_IDLE;
                    next_s.done = !s.co_valid;
                end
            end
            ST_CAST: begin
                if (co_ack) begin
                    next_s.co_valid = 1'b0;
                    next_s.st       = ST_IDLE;
                    next_s.done     = 1'b1;
                end
            end
            default: begin
                next_s.st = ST_IDLE;
            end
        endcase

        if (next_s.done) begin
            next_s.last_dsi   = next_s.dsi;
            next_s.last_align = next_s.align;
            next_s.last_priv  = next_s.priv;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s       <= '0;
            s.st    <= ST_IDLE;
            s.op    <= OP_LOAD;
            s.bcast <= CFG_RST;
            s.den   <= CFG_RST;
            s.dlock <= CFG_RST;
            s.l2en  <= CFG_RST;
        end else begin
            s <= next_s;
        end
    end

    // Cache state arrays
    always_ff @(posedge clk) begin
        if (aw_tag_en) dtag[aw_set][aw_way] <= s.tag;
        if (srst || s.dfi) begin
            for (int i = 0; i < NUM_SETS; i++) begin
                dvalid[i] <= '0;
                dmod[i]   <= '0;
                dplru[i]  <= PLRU_RST;
            end
        end else begin
            if (aw_en) begin
                dvalid[aw_set][aw_way] <= aw_valid;
                dmod[aw_set][aw_way]   <= aw_mod;
            end
            if (ap_en) dplru[aw_set] <= l1m_plru_hit(dplru[aw_set], aw_way);
            if (sn_en) dvalid[snp_set][sn_way] <= 1'b0;
        end
        if (srst || s.ifi) begin
            for (int i = 0; i < NUM_SETS; i++) begin
                ivalid[i] <= '0;
                iplru[i]  <= PLRU_RST;
            end
        end else if (i_clr) begin
            ivalid[aw_set] <= '0;
        end else if (i_fill) begin
            ivalid[aw_set][i_way] <= 1'b1;
            iplru[aw_set]         <= l1m_plru_hit(iplru[aw_set], i_way);
        end
    end

    // Outputs
    assign reg_rdata     = s.rdata;
    assign op_ready      = (s.st == ST_IDLE);
    assign op_done       = s.done;
    assign op_way        = s.way;
    assign exc_dsi       = s.dsi;
    assign exc_align     = s.align;
    assign exc_priv      = s.priv;
    assign ref_bit_set   = s.refb;
    assign tlb_lru_touch = s.refb;
    assign bus_req       = (s.st == ST_BCAST);
    assign bus_kind      = s.op;
    assign l2_fwd        = s.l2f;
    assign l2_kind       = s.op;
    assign wb_req        = (s.st == ST_WB);
    assign fill_req      = (s.st == ST_FILL);
    assign co_req        = (s.st == ST_CAST);
    assign co_to_l2      = s.l2en;
    assign co_set        = s.co_set;
    assign co_tag        = s.co_tag;
    assign blk_clear     = (s.st == ST_ZERO);
    assign blk_set       = s.set;
    assign blk_way       = s.way;

endmodule : l1m_ctrl

// [verif/l1m_far_model.sv]
`timescale 1ns/1ps
module l1m_far_model (
    // Clock, reset and reply delay
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic [3:0] dly,
    // Requests from the cache
    input  wire logic       bus_req,
    input  wire logic       wb_req,
    input  wire logic       fill_req,
    input  wire logic       co_req,
    // One-cycle replies
    output logic            bus_ack,
    output logic            wb_ack,
    output logic            fill_done,
    output logic            co_ack
);
    logic [3:0] cnt;
    wire any_ack = bus_ack || wb_ack || fill_done || co_ack;
    wire go = (cnt == dly) && !any_ack && !srst;
    always_ff @(posedge clk) begin
        cnt       <= (srst || go || any_ack || !(bus_req || wb_req || fill_req || co_req))
                     ? 4'h0 : cnt + 4'h1;
        bus_ack   <= go && bus_req;
        wb_ack    <= go && wb_req;
        fill_done <= go && fill_req;
        co_ack    <= go && co_req;
    end
endmodule : l1m_far_model

// [verif/l1m_asserts.sv]
`timescale 1ns/1ps
module l1m_asserts
    import l1m_pkg::*;
(
    input wire logic       clk,
    input wire logic       srst,
    input wire logic       op_valid,
    input wire logic       op_ready,
    input wire l1m_op_t    op_kind,
    input wire logic       xlat_hit,
    input wire logic       prot_load_ok,
    input wire logic       prot_store_ok,
    input wire logic [3:0] memory_attribute_bits,
    input wire logic       problem_state_privilege,
    input wire logic       op_done,
    input wire logic       exc_dsi,
    input wire logic       exc_align,
    input wire logic       exc_priv,
    input wire logic       ref_bit_set,
    input wire logic       bus_req,
    input wire logic       l2_fwd,
    input wire logic       blk_clear
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire acc = op_valid && op_ready;
    a_exc_done: assert property ((exc_dsi || exc_align || exc_priv) |-> op_done)
        else $error("exception without done");
    a_zero_align: assert property (acc && op_kind == OP_ZERO && xlat_hit && prot_store_ok
        && memory_attribute_bits[MA_I] |=> exc_align && op_done) else $error("no align");
    a_zero_prot: assert property (acc && op_kind == OP_ZERO && !prot_store_ok |=> exc_dsi)
        else $error("zero protection missed");
    a_inval_priv: assert property (acc && op_kind == OP_INVAL && problem_state_privilege
        |=> exc_priv && op_done) else $error("user invalidate allowed");
    a_icbi_quiet: assert property (acc && op_kind == OP_ICBI |=> op_done && !exc_dsi && !bus_req)
        else $error("icache invalidate misbehaved");
    a_clear_four: assert property ($rose(blk_clear) |-> blk_clear [*4] ##1 !blk_clear)
        else $error("zero clear not four cycles");
    a_touch_noop: assert property (acc && op_kind == OP_TOUCH && !xlat_hit
        |=> op_done && !ref_bit_set) else $error("touch not a no-op");
    a_store_fwd: assert property (acc && op_kind inside {OP_STORE, OP_FLUSH} && xlat_hit
        && prot_load_ok |=> l2_fwd) else $error("no forward to L2");
endmodule : l1m_asserts
bind l1m_ctrl l1m_asserts i_chk (.*);

// [verif/l1m_ctrl_test.sv]
`timescale 1ns/1ps
module l1m_ctrl_test
    import l1m_pkg::*;
;
    logic clk, srst, reg_wr, reg_rd, op_valid, op_ready, xlat_hit, prot_load_ok, prot_store_ok;
    logic seg_direct_store, problem_state_privilege, op_done, exc_dsi, exc_align, exc_priv;
    logic ref_bit_set, tlb_lru_touch, bus_req, bus_ack, l2_fwd, wb_req, wb_ack, fill_req;
    logic fill_done, co_req, co_to_l2, co_ack, blk_clear, snp_valid, snp_kill, snp_coherent;
    logic [3:0]       reg_addr, memory_attribute_bits, dly;
    logic [31:0]      reg_wdata, reg_rdata;
    logic [SET_W-1:0] op_set, co_set, blk_set, snp_set;
    logic [TAG_W-1:0] op_tag, co_tag, snp_tag;
    logic [WAY_W-1:0] op_way, blk_way, way;
    logic [2:0]       ex;
    l1m_op_t          op_kind, bus_kind, l2_kind;
    int               n_fail, n_checks, cyc, nb, nw, nf, nl, nc, nr, nco, i;
    l1m_ctrl i_dut (.*);
    l1m_far_model i_far (.*);
    always #5 clk = ~clk;
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run
    always @(posedge clk) if (++cyc > 20000) begin
        n_fail++;
        complete_run();
    end
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", s, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk) reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk) reg_rd <= 1'b0;
        @(negedge clk) chk("reg_rdata", reg_rdata, e);
    endtask : rd
    // Flags: xlat, load ok, store ok, user privilege
    task automatic op(input l1m_op_t k, input logic [19:0] t, input logic [3:0] ma,
                      input logic [3:0] f);
        int n;
        {n, nb, nw, nf, nl, nc, nr, nco} = '0;
        @(posedge clk) {op_valid, op_tag, memory_attribute_bits, xlat_hit,
            prot_load_ok, prot_store_ok, problem_state_privilege} <= {1'b1, t, ma, f};
        op_kind <= k;
        @(posedge clk) op_valid <= 1'b0;
        do begin
            @(negedge clk);
            {nb, nw, nf} = {nb + bus_req, nw + wb_req, nf + fill_req};
            {nr, nco} = {nr + (ref_bit_set & tlb_lru_touch), nco + (co_req & co_to_l2)};
            {nl, nc} = {nl + l2_fwd, nc + blk_clear};
            {ex, way} = {exc_dsi, exc_align, exc_priv, op_way};
        end while (op_done !== 1'b1 && ++n < 300);
        chk("op_done", op_done, 1'b1);
    endtask : op
    task automatic snoop(input logic c, input logic [19:0] t);
        @(posedge clk) {snp_valid, snp_kill, snp_coherent, snp_tag} <= {2'b11, c, t};
        @(posedge clk) snp_valid <= 1'b0;
    endtask : snoop
    initial begin
        {clk, srst, reg_wr, reg_rd, op_valid, snp_valid, snp_kill, snp_coherent} = 8'h40;
        {reg_addr, reg_wdata, op_set, op_tag, memory_attribute_bits, dly} = '0;
        op_kind = OP_LOAD;
        {xlat_hit, prot_load_ok, prot_store_ok, seg_direct_store} = '0;
        {problem_state_privilege, snp_set, snp_tag} = '0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        rd(REG_CFG, 32'h0);
        rd(4'h8, 32'h0);
        wr(REG_CFG, 32'h0000000A);
        rd(REG_CFG, 32'h0000000A);
        for (i = 0; i < 8; i++) begin
            dly <= 4'(i);
            op(OP_TOUCH, 20'(i + 1), 4'h0, 4'hE);
            chk("fill_way", way, i);
            chk("touch_ref", nr, 1);
        end
        op(OP_LOAD, 20'h1, 4'h0, 4'hE);
        chk("hit_way", way, 0);
        op(OP_TOUCH, 20'h9, 4'h0, 4'hE);
        chk("plru_way", way, 4);
        op(OP_TOUCH, 20'hA, 4'h0, 4'hE);
        chk("plru_way2", way, 2);
        op(OP_ZERO, 20'hA, 4'h2, 4'hE);
        chk("zero_bus", nb != 0, 1'b1);
        chk("zero_clear", nc, 4);
        op(OP_FLUSH, 20'hA, 4'h0, 4'hC);
        chk("flush_wb", {nw != 0, 8'(nb), 8'(nl)}, {1'b1, 8'h0, 8'h1});
        chk("l2_kind", l2_kind, OP_FLUSH);
        op(OP_FLUSH, 20'hA, 4'h0, 4'hC);
        chk("flush_miss", nw, 0);
        op(OP_LOAD, 20'hA, 4'h0, 4'hE);
        chk("refill_way", way, 2);
        op(OP_ZERO, 20'h1, 4'h8, 4'hE);
        chk("zero_wt", ex, 3'b010);
        op(OP_ZERO, 20'h1, 4'h4, 4'hE);
        chk("zero_ci", ex, 3'b010);
        op(OP_ZERO, 20'h1, 4'h0, 4'hC);
        chk("zero_prot", ex, 3'b100);
        op(OP_ZERO, 20'hB, 4'h0, 4'hE);
        chk("zero_alloc", {8'(nc), 8'(nf), blk_way}, {8'h4, 8'h0, 3'h6});
        wr(REG_CFG, 32'h0000000B);
        op(OP_STORE, 20'hB, 4'h0, 4'hC);
        chk("store_wb", {nw != 0, nb != 0}, 2'b11);
        op(OP_STORE, 20'hB, 4'h0, 4'hC);
        chk("store_clean", nw, 0);
        op(OP_INVAL, 20'hB, 4'h0, 4'hF);
        chk("inval_user", ex, 3'b001);
        op(OP_STORE, 20'hB, 4'h0, 4'h6);
        chk("store_xlat", ex, 3'b100);
        wr(REG_CFG, 32'h00000001);
        op(OP_FLUSH, 20'hB, 4'h4, 4'hC);
        chk("flush_off", {ex, 8'(nl)}, {3'b000, 8'h1});
        op(OP_ZERO, 20'hB, 4'h0, 4'hE);
        chk("zero_off", ex, 3'b010);
        op(OP_TOUCH, 20'h30, 4'h0, 4'hE);
        chk("touch_off", nf + nr, 0);
        wr(REG_CFG, 32'h0000000A);
        op(OP_TOUCH, 20'h31, 4'h0, 4'h6);
        chk("touch_miss", nf + nr, 0);
        snoop(1'b0, 20'h1);
        op(OP_LOAD, 20'h1, 4'h0, 4'hE);
        chk("snoop_plain", nf, 0);
        snoop(1'b1, 20'h9);
        op(OP_LOAD, 20'h9, 4'h0, 4'hE);
        chk("snoop_kill", nf != 0, 1'b1);
        op(OP_IFILL, 20'h1, 4'h0, 4'h0);
        op(OP_IFILL, 20'h2, 4'h0, 4'h0);
        chk("ifill_way", way, 1);
        op(OP_ICBI, 20'h0, 4'h0, 4'h0);
        op(OP_IFILL, 20'h3, 4'h0, 4'h0);
        chk("icbi_way", way, 0);
        op(OP_ZERO, 20'hC, 4'h0, 4'hE);
        op(OP_LOAD, 20'h8, 4'h0, 4'hE);
        op(OP_LOAD, 20'h9, 4'h0, 4'hE);
        op(OP_LOAD, 20'h1, 4'h0, 4'hE);
        op(OP_TOUCH, 20'hD, 4'h0, 4'hE);
        chk("castout", {nco != 0, co_tag, way}, {1'b1, 20'hC, 3'h6});
        wr(REG_CFG, 32'h0000001A);
        op(OP_LOAD, 20'h1, 4'h0, 4'hE);
        chk("flash_way", way, 0);
        complete_run();
    end
endmodule : l1m_ctrl_test
